//--- shared/nfc_defs.svh
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH
`define NFC_CMD_READ1 8'h00
`define NFC_CMD_READ2 8'h30
`define NFC_CMD_PROG1 8'h80
`define NFC_CMD_PROG2 8'h10
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_RESET 8'hFF
`define NFC_SPARE_COL_X8 12'h800
`define NFC_SPARE_COL_X16 12'h400
`define NFC_PAGE_LEN_X8 12'h840
`define NFC_PAGE_LEN_X16 12'h420
`define NFC_ERASED_X8 8'hFF
`define NFC_ERASED_X16 16'hFFFF
`define NFC_STAT_FAIL_BIT 0
`define NFC_BLK_LSB 6
`define NFC_BLOCKS 1024
`define NFC_CLK_MHZ 20
`define NFC_LOAD_TIME_US 25
`define NFC_LOAD_CYC (`NFC_LOAD_TIME_US * `NFC_CLK_MHZ)
`define NFC_RESET_TIME_US 500
`define NFC_RESET_CYC (`NFC_RESET_TIME_US * `NFC_CLK_MHZ)
`define NFC_PROG_TIME_US 700
`define NFC_PROG_CYC (`NFC_PROG_TIME_US * `NFC_CLK_MHZ)
`define NFC_ERASE_TIME_US 3000
`define NFC_ERASE_CYC (`NFC_ERASE_TIME_US * `NFC_CLK_MHZ)
`define NFC_WB_TIME_NS 100
`define NFC_WB_CYC ((`NFC_WB_TIME_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_WHR_TIME_NS 60
`define NFC_WHR_CYC ((`NFC_WHR_TIME_NS * `NFC_CLK_MHZ + 999) / 1000)
`endif

//--- shared/nfc_pkg.sv
package nfc_pkg;
    typedef enum logic [2:0] {
        NFC_OP_READ, NFC_OP_PROG, NFC_OP_ERASE, NFC_OP_RESET, NFC_OP_SCAN, NFC_OP_STATUS
    } nfc_op_type;
    typedef enum {
        S_IDLE, S_CHECK, S_CMD1, S_ADDR, S_CMD2, S_BUSY, S_WDATA, S_RDATA,
        S_STCMD, S_STWAIT, S_STREAD, S_DONE
    } nfc_state_type;
endpackage

//--- shared/nfc_bbt_if.sv
`timescale 1ns/1ps
interface nfc_bbt_if #(parameter int AW = 10);
    logic [AW-1:0] addr;
    logic wr_en;
    logic rd_bad;
    modport mem(input addr, input wr_en, output rd_bad);
    modport ctl(output addr, output wr_en, input rd_bad);
endinterface

//--- hdl/nfc_bbt.sv
`timescale 1ns/1ps
module nfc_bbt #(
    parameter int DEPTH = 1024
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    nfc_bbt_if.mem bbt
);
    logic [DEPTH-1:0] bad_r;
    logic rd_r;

    // Table is volatile; a fresh scan rebuilds it after power-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bad_r <= '0;
            rd_r <= 1'b0;
        end else if (en) begin
            if (bbt.wr_en) begin
                bad_r[bbt.addr] <= 1'b1;
            end
            rd_r <= bad_r[bbt.addr];
        end
    end

    assign bbt.rd_bad = rd_r;
endmodule

//--- hdl/nfc_ctrl.sv
`timescale 1ns/1ps
`include "nfc_defs.svh"
// Overview of operation
// - Scanned bad blocks go into a table, and erase or program of a listed block is refused.
// - Every program or erase that leaves busy before its timeout is followed by a status read, and a failure retires the block.
// - Read data errors never retire a block; single-bit errors are left to ECC upstream.
// - A failed block is never erased again, leaving the page copy to the user.
// - Chip enable is released while program data is awaited and the transfer then resumes.
// - A page transfer runs at most 2112 bytes or 1056 words, spare area included, when its start column lies inside the page.
// - The upper eight data lines are driven to zero in every command and address cycle.
module nfc_ctrl import nfc_pkg::*; #(
    parameter bit WIDE = 1'b0,
    parameter int RESET_CYC = `NFC_RESET_CYC,
    parameter int PROG_CYC = `NFC_PROG_CYC,
    parameter int ERASE_CYC = `NFC_ERASE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic cmd_valid,
    input wire nfc_op_type cmd_op,
    input wire logic [15:0] cmd_row,
    input wire logic [11:0] cmd_col,
    output logic cmd_ready,
    input wire logic [15:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic fail,
    output logic refused,
    output logic timeout,
    output logic bad_block,
    output logic [7:0] status,
    output logic nand_ce_n,
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_we_n,
    output logic read_strobe_n,
    output logic nand_wp_n,
    output logic [15:0] nand_io_out,
    output logic nand_io_oe_n,
    input wire logic [15:0] nand_io_in,
    input wire logic nand_rb_n
);
    localparam logic [16:0] LOAD_LIM = 17'(`NFC_LOAD_CYC);
    localparam logic [16:0] WB_LIM = 17'(`NFC_WB_CYC);
    localparam logic [2:0] WHR_LIM = 3'(`NFC_WHR_CYC);
    localparam logic [11:0] PAGE_LEN = WIDE ? `NFC_PAGE_LEN_X16 : `NFC_PAGE_LEN_X8;
    localparam logic [11:0] SPARE_COL = WIDE ? `NFC_SPARE_COL_X16 : `NFC_SPARE_COL_X8;

    logic rs1_r, rst_s_r;
    logic [15:0] io_s1_r, io_s2_r;
    logic rb_s1_r, rb_s2_r;
    nfc_state_type state_r;
    nfc_op_type op_r;
    logic [15:0] row_r, wdat_r;
    logic [11:0] col_r, len_r, cnt_r;
    logic [2:0] cyc_r;
    logic [1:0] idx_r;
    logic [16:0] tmr_r;
    logic have_r, page_r, mark_r;
    nfc_bbt_if #(.AW(10)) bbt ();

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_s_r <= rs1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            io_s1_r <= 16'h0000;
            io_s2_r <= 16'h0000;
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
        end else if (en) begin
            io_s1_r <= nand_io_in;
            io_s2_r <= io_s1_r;
            rb_s1_r <= nand_rb_n;
            rb_s2_r <= rb_s1_r;
        end
    end

    assign bbt.addr = row_r[15:`NFC_BLK_LSB];
    assign bbt.wr_en = mark_r;
    nfc_bbt #(.DEPTH(`NFC_BLOCKS)) u_bbt (.clk(clk), .rst_n(rst_s_r), .en(en), .bbt(bbt));

    wire wr_cyc = (state_r == S_CMD1) || (state_r == S_ADDR) || (state_r == S_CMD2) ||
                  (state_r == S_STCMD) || (state_r == S_WDATA && have_r);
    wire rd_cyc = (state_r == S_RDATA) || (state_r == S_STREAD);
    wire bus_last = wr_cyc ? (cyc_r == 3'd1) : (cyc_r == 3'd4);
    wire [15:0] rd_word = {WIDE ? io_s2_r[15:8] : 8'h00, io_s2_r[7:0]};
    wire erased = WIDE ? (rd_word == `NFC_ERASED_X16) : (rd_word[7:0] == `NFC_ERASED_X8);
    wire guarded = (op_r == NFC_OP_ERASE) || (op_r == NFC_OP_PROG);
    wire [7:0] cmd1 = (op_r == NFC_OP_PROG) ? `NFC_CMD_PROG1 :
                      (op_r == NFC_OP_ERASE) ? `NFC_CMD_ERASE1 :
                      (op_r == NFC_OP_RESET) ? `NFC_CMD_RESET :
                      (op_r == NFC_OP_STATUS) ? `NFC_CMD_STATUS : `NFC_CMD_READ1;
    wire [7:0] cmd2 = (op_r == NFC_OP_PROG) ? `NFC_CMD_PROG2 :
                      (op_r == NFC_OP_ERASE) ? `NFC_CMD_ERASE2 : `NFC_CMD_READ2;
    wire [7:0] col_hi = WIDE ? {5'h00, col_r[10:8]} : {4'h0, col_r[11:8]};
    wire [7:0] addr_byte = (idx_r == 2'd0) ? col_r[7:0] : (idx_r == 2'd1) ? col_hi :
                           (idx_r == 2'd2) ? row_r[7:0] : row_r[15:8];
    wire [7:0] bus_byte = (state_r == S_ADDR) ? addr_byte : (state_r == S_CMD2) ? cmd2 :
                          (state_r == S_STCMD) ? `NFC_CMD_STATUS : cmd1;
    wire is_data = (state_r == S_WDATA);
    wire [15:0] bus_word = is_data ? wdat_r : {8'h00, bus_byte};
    wire [16:0] busy_lim = (op_r == NFC_OP_RESET) ? 17'(RESET_CYC) : (op_r == NFC_OP_PROG) ? 17'(PROG_CYC) :
                           (op_r == NFC_OP_ERASE) ? 17'(ERASE_CYC) : LOAD_LIM;
    wire [11:0] start_len = PAGE_LEN - cmd_col;

    always_ff @(posedge clk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            state_r <= S_IDLE;
            op_r <= NFC_OP_READ;
            row_r <= 16'h0000;
            col_r <= 12'h000;
            len_r <= 12'h000;
            cnt_r <= 12'h000;
            wdat_r <= 16'h0000;
            cyc_r <= 3'd0;
            idx_r <= 2'd0;
            tmr_r <= 17'h00000;
            have_r <= 1'b0;
            page_r <= 1'b0;
            mark_r <= 1'b0;
            cmd_ready <= 1'b0;
            wr_ready <= 1'b0;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            refused <= 1'b0;
            timeout <= 1'b0;
            bad_block <= 1'b0;
            status <= 8'h00;
            nand_ce_n <= 1'b1;
            nand_cle <= 1'b0;
            nand_ale <= 1'b0;
            nand_we_n <= 1'b1;
            read_strobe_n <= 1'b1;
            nand_wp_n <= 1'b0;
            nand_io_out <= 16'h0000;
            nand_io_oe_n <= 1'b1;
        end else if (en) begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            mark_r <= 1'b0;
            nand_wp_n <= 1'b1;
            if (wr_cyc) begin
                cyc_r <= bus_last ? 3'd0 : cyc_r + 3'd1;
                nand_we_n <= (cyc_r != 3'd0);
                if (cyc_r == 3'd0) begin
                    nand_ce_n <= 1'b0;
                    nand_cle <= (state_r != S_ADDR) && !is_data;
                    nand_ale <= (state_r == S_ADDR);
                    nand_io_out <= bus_word;
                    nand_io_oe_n <= 1'b0;
                end
            end else if (rd_cyc) begin
                cyc_r <= bus_last ? 3'd0 : cyc_r + 3'd1;
                nand_cle <= 1'b0;
                nand_ale <= 1'b0;
                nand_io_oe_n <= 1'b1;
                if (cyc_r == 3'd0) begin
                    read_strobe_n <= 1'b0;
                end else if (cyc_r == 3'd3) begin
                    read_strobe_n <= 1'b1;
                end
            end else begin
                nand_cle <= 1'b0;
                nand_ale <= 1'b0;
                nand_io_oe_n <= 1'b1;
            end
            case (state_r)
                S_IDLE: begin
                    nand_ce_n <= 1'b1;
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op_r <= cmd_op;
                        fail <= 1'b0;
                        refused <= 1'b0;
                        timeout <= 1'b0;
                        bad_block <= 1'b0;
                        page_r <= 1'b0;
                        cyc_r <= 3'd0;
                        if (cmd_op == NFC_OP_SCAN) begin
                            row_r <= {cmd_row[15:`NFC_BLK_LSB], 6'h00};
                            col_r <= SPARE_COL;
                            len_r <= 12'h001;
                        end else begin
                            row_r <= cmd_row;
                            col_r <= cmd_col;
                            len_r <= start_len;
                        end
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    cyc_r <= 3'd1;
                    if (cyc_r != 3'd0) begin
                        cyc_r <= 3'd0;
                        idx_r <= (op_r == NFC_OP_ERASE) ? 2'd2 : 2'd0;
                        if (guarded && bbt.rd_bad) begin
                            refused <= 1'b1;
                            state_r <= S_DONE;
                        end else begin
                            state_r <= S_CMD1;
                        end
                    end
                end
                S_CMD1: if (bus_last) begin
                    tmr_r <= 17'h00000;
                    state_r <= (op_r == NFC_OP_RESET) ? S_BUSY : (op_r == NFC_OP_STATUS) ? S_STWAIT : S_ADDR;
                end
                S_ADDR: if (bus_last) begin
                    idx_r <= idx_r + 2'd1;
                    cnt_r <= 12'h000;
                    if (idx_r == 2'd3) begin
                        state_r <= (op_r == NFC_OP_PROG) ? S_WDATA : S_CMD2;
                    end
                end
                S_CMD2: if (bus_last) begin
                    tmr_r <= 17'h00000;
                    state_r <= S_BUSY;
                end
                S_BUSY: begin
                    tmr_r <= tmr_r + 17'h00001;
                    if (tmr_r >= WB_LIM && rb_s2_r) begin
                        cnt_r <= 12'h000;
                        state_r <= (op_r == NFC_OP_RESET) ? S_DONE : guarded ? S_STCMD : S_RDATA;
                    end else if (tmr_r >= busy_lim) begin
                        timeout <= 1'b1;
                        state_r <= S_DONE;
                    end
                end
                S_WDATA: begin
                    if (!have_r) begin
                        wr_ready <= 1'b1;
                        nand_ce_n <= 1'b1;
                        if (wr_valid && wr_ready) begin
                            wr_ready <= 1'b0;
                            wdat_r <= wr_data;
                            have_r <= 1'b1;
                        end
                    end else if (bus_last) begin
                        have_r <= 1'b0;
                        cnt_r <= cnt_r + 12'h001;
                        if (cnt_r == len_r - 12'h001) begin
                            state_r <= S_CMD2;
                        end
                    end
                end
                S_RDATA: if (cyc_r == 3'd3) begin
                    rd_data <= rd_word;
                    rd_valid <= (op_r == NFC_OP_READ);
                end else if (bus_last) begin
                    cnt_r <= cnt_r + 12'h001;
                    if (op_r == NFC_OP_SCAN) begin
                        if (!erased) begin
                            bad_block <= 1'b1;
                            mark_r <= 1'b1;
                            state_r <= S_DONE;
                        end else if (!page_r) begin
                            page_r <= 1'b1;
                            row_r <= row_r + 16'h0001;
                            idx_r <= 2'd0;
                            state_r <= S_CMD1;
                        end else begin
                            state_r <= S_DONE;
                        end
                    end else if (cnt_r == len_r - 12'h001) begin
                        state_r <= S_DONE;
                    end
                end
                S_STCMD: if (bus_last) begin
                    tmr_r <= 17'h00000;
                    state_r <= S_STWAIT;
                end
                S_STWAIT: begin
                    tmr_r <= tmr_r + 17'h00001;
                    if (tmr_r[2:0] >= WHR_LIM) begin
                        state_r <= S_STREAD;
                    end
                end
                S_STREAD: if (bus_last) begin
                    status <= rd_word[7:0];
                    if (guarded && rd_word[`NFC_STAT_FAIL_BIT]) begin
                        fail <= 1'b1;
                        mark_r <= 1'b1;
                    end
                    state_r <= S_DONE;
                end
                S_DONE: begin
                    nand_ce_n <= 1'b1;
                    done <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_s_r);

    chk_erase_refused: assert property (en && state_r == S_CHECK && cyc_r != 3'd0 && guarded && bbt.rd_bad
        |=> refused && state_r == S_DONE) else $error("listed block not refused");
    chk_status_retire: assert property (en && state_r == S_STREAD && bus_last && guarded && rd_word[0]
        |=> fail && mark_r ##2 bbt.rd_bad || !en) else $error("status failure did not retire block");
    chk_read_no_retire: assert property (mark_r |-> $past(state_r) == S_STREAD
        || ($past(state_r) == S_RDATA && op_r == NFC_OP_SCAN)) else $error("block retired from read data");
    chk_failed_no_erase: assert property (state_r == S_CHECK ##1 state_r == S_CMD1
        |-> !(guarded && $past(bbt.rd_bad))) else $error("failed block erased again");
    chk_ce_released: assert property (en && state_r == S_WDATA && !have_r
        |=> nand_ce_n) else $error("chip enable held while waiting for data");
    chk_page_length: assert property (cnt_r <= PAGE_LEN) else $error("page transfer too long");
    chk_upper_zero: assert property ((nand_cle || nand_ale) && !nand_io_oe_n
        |-> nand_io_out[15:8] == 8'h00) else $error("upper data lines not zero");
    chk_four_addr: assert property (en && state_r == S_CMD1 && bus_last && op_r == NFC_OP_READ
        |=> state_r == S_ADDR && idx_r == 2'd0 ##[8:40] state_r == S_CMD2) else $error("address cycles wrong");
    chk_busy_bound: assert property (state_r == S_BUSY |-> tmr_r <= busy_lim) else $error("busy wait overran");
endmodule

//--- testbench/nfc_flash_model.sv
`timescale 1ns/1ps
module nfc_flash_model (
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [15:0] io,
    output logic [15:0] dout,
    output logic rb_n
);
    logic [7:0] mem [int];
    logic [7:0] page_reg [0:2111];
    logic [7:0] adr [0:3];
    logic [7:0] q = 8'h5A;
    logic [7:0] stat = 8'hC0;
    logic stat_mode = 1'b0;
    logic slow = 1'b0;
    int fail_blk = -1;
    int acnt = 0;
    int col = 0;
    int row = 0;
    time busy_end = 0;

    function automatic logic [7:0] rdm(input int k);
        return mem.exists(k) ? mem[k] : 8'hFF;
    endfunction

    initial begin
        mem[16'h00C1 * 4096 + 2048] = 8'h00; // marker on second page; block zero stays clean
    end

    always #10 rb_n = ($time >= busy_end);

    // Pins ignored while deselected, page register kept
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            stat_mode = (io[7:0] == 8'h70);
            case (io[7:0])
                8'h00, 8'h60: acnt = 0;
                8'h80: begin
                    acnt = 0;
                    foreach (page_reg[c]) page_reg[c] = 8'hFF;
                end
                8'h30: begin
                    foreach (page_reg[c]) page_reg[c] = rdm(row * 4096 + c);
                    busy_end = $time + (slow ? 30000 : 2000);
                end
                8'h10: begin
                    stat = ((row >> 6) == fail_blk) ? 8'hC1 : 8'hC0;
                    if (stat == 8'hC0) begin
                        foreach (page_reg[c]) mem[row * 4096 + c] = rdm(row * 4096 + c) & page_reg[c];
                    end
                    busy_end = $time + 3000;
                end
                8'hD0: begin
                    stat = ({adr[1], adr[0]} >> 6 == fail_blk) ? 8'hC1 : 8'hC0;
                    busy_end = $time + 3000;
                end
                8'hFF: begin
                    // Reset leaves a clean status, no stale fail bit
                    stat = 8'hC0;
                    busy_end = $time + 5000;
                end
                default: ;
            endcase
        end else if (!ce_n && ale) begin
            adr[acnt & 3] = io[7:0];
            acnt++;
            col = {adr[1][3:0], adr[0]};
            row = {adr[3], adr[2]};
        end else if (!ce_n) begin
            if (col < 2112) page_reg[col] = io[7:0];
            col++;
        end
    end

    always @(negedge re_n) begin
        if (!ce_n) begin
            q = stat_mode ? stat : (col < 2112 ? page_reg[col] : 8'h00);
            col++;
        end
    end

    // Released bus shows the inverse from 15 ns after the strobe rises, not a stale copy
    always @(posedge re_n) #15 q = ~q;
    assign dout = {~q, q};
endmodule

//--- testbench/nfc_ctrl_test.sv
`timescale 1ns/1ps
module nfc_ctrl_test import nfc_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
    nfc_op_type cmd_op = NFC_OP_STATUS;
    logic [15:0] cmd_row = 16'h0000, wr_data = 16'h0000, rd_data, nand_io_out, nand_io_in;
    logic [11:0] cmd_col = 12'h000;
    logic cmd_ready, wr_ready, rd_valid, done, fail, refused, timeout, bad_block;
    logic [7:0] status;
    logic nand_ce_n, nand_cle, nand_ale, nand_we_n, read_strobe_n, nand_wp_n, nand_io_oe_n, nand_rb_n;
    logic [15:0] got [$];
    logic [15:0] wq [$];
    int num_errors = 0, n_compared = 0, cyc = 0, we_falls = 0, ce_rises = 0;

    nfc_ctrl #(.WIDE(1'b0), .RESET_CYC(200), .PROG_CYC(200), .ERASE_CYC(200)) dut (
        .clk(clk), .rst_n(rst_n), .en(en), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_row(cmd_row),
        .cmd_col(cmd_col), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .fail(fail), .refused(refused),
        .timeout(timeout), .bad_block(bad_block), .status(status), .nand_ce_n(nand_ce_n),
        .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n), .read_strobe_n(read_strobe_n),
        .nand_wp_n(nand_wp_n), .nand_io_out(nand_io_out), .nand_io_oe_n(nand_io_oe_n),
        .nand_io_in(nand_io_in), .nand_rb_n(nand_rb_n));

    nfc_flash_model model (
        .ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n), .re_n(read_strobe_n),
        .io(nand_io_oe_n ? ~nand_io_in : nand_io_out), .dout(nand_io_in), .rb_n(nand_rb_n));

    initial forever #25 clk = ~clk;
    always @(negedge nand_we_n) we_falls++;
    always @(posedge nand_ce_n) ce_rises++;

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // One command through the port; program words come from wq, read words land in got
    task automatic run_cmd(input nfc_op_type op, input logic [15:0] row, input logic [11:0] col);
        int wi;
        logic tk, fin;
        wi = 0;
        fin = 1'b0;
        got.delete();
        cmd_op = op;
        cmd_row = row;
        cmd_col = col;
        cmd_valid = 1'b1;
        wr_valid = (wq.size() > 0);
        wr_data = (wq.size() > 0) ? wq[0] : 16'h0000;
        for (int k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        #2 cmd_valid = 1'b0;
        for (int k = 0; k < 30000 && !fin; k++) begin
            @(negedge clk);
            if (rd_valid === 1'b1) got.push_back(rd_data);
            tk = (wr_valid === 1'b1 && wr_ready === 1'b1);
            fin = (done === 1'b1);
            @(posedge clk);
            #2;
            if (tk) wi++;
            wr_valid = (wi < wq.size());
            wr_data = (wi < wq.size()) ? wq[wi] : 16'h0000;
        end
        chk(fin, "command never finished");
        wq.delete();
    endtask

    task automatic t_reset();
        chk(nand_ce_n === 1'b1 && nand_we_n === 1'b1 && nand_wp_n === 1'b0 && nand_io_oe_n === 1'b1, "reset pins");
        chk(cmd_ready === 1'b0, "ready during reset");
        @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(cmd_ready === 1'b1, "not ready after reset");
        @(posedge clk);
        #2 en = 1'b0;
        cmd_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk(cmd_ready === 1'b1 && nand_ce_n === 1'b1 && we_falls == 0, "state moved while frozen");
        @(posedge clk);
        #2 cmd_valid = 1'b0;
        en = 1'b1;
        @(posedge clk);
        #2;
        $display("test reset done");
    endtask

    task automatic t_scan();
        run_cmd(NFC_OP_SCAN, 16'h0000, 12'h000);
        chk(bad_block === 1'b0, "block zero flagged");
        run_cmd(NFC_OP_SCAN, 16'h00C0, 12'h000);
        chk(bad_block === 1'b1, "second page marker missed");
        $display("test scan done");
    endtask

    task automatic t_refuse();
        int w0;
        w0 = we_falls;
        run_cmd(NFC_OP_ERASE, 16'h00C0, 12'h000);
        chk(refused === 1'b1, "erase of marked block not refused");
        chk(we_falls == w0, "pins moved on refused erase");
        w0 = we_falls;
        run_cmd(NFC_OP_ERASE, 16'h0080, 12'h000);
        chk(refused === 1'b0 && fail === 1'b0 && status === 8'hC0, "erase of good block");
        chk(model.adr[0] === 8'h80 && model.adr[1] === 8'h00 && we_falls - w0 == 5, "erase cycles");
        $display("test refuse done");
    endtask

    task automatic t_prog_read();
        int c0;
        c0 = ce_rises;
        wq = '{16'h0012, 16'h0034, 16'h0056, 16'h0078};
        run_cmd(NFC_OP_PROG, 16'h0040, 12'h83C);
        chk({model.adr[0], model.adr[1], model.adr[2], model.adr[3]} === 32'h3C084000, "address cycles");
        chk(ce_rises - c0 >= 3, "chip enable held during loading");
        chk(fail === 1'b0 && status === 8'hC0 && refused === 1'b0, "program status");
        run_cmd(NFC_OP_READ, 16'h0040, 12'h83C);
        chk(got.size() == 4, "read word count");
        chk(got.size() == 4 && got[0] === 16'h0012 && got[3] === 16'h0078, "read data");
        wq = '{16'h00A5, 16'h005A};
        run_cmd(NFC_OP_PROG, 16'h0041, 12'h83E);
        chk(refused === 1'b0 && fail === 1'b0, "read retired a block");
        $display("test program read done");
    endtask

    task automatic t_fail();
        model.fail_blk = 5;
        wq = '{16'h0001, 16'h0002};
        run_cmd(NFC_OP_PROG, 16'h0140, 12'h83E);
        chk(fail === 1'b1 && status[0] === 1'b1, "status fail not reported");
        run_cmd(NFC_OP_ERASE, 16'h0140, 12'h000);
        chk(refused === 1'b1, "failed block erased again");
        $display("test fail done");
    endtask

    task automatic t_timeout();
        model.slow = 1'b1;
        run_cmd(NFC_OP_READ, 16'h0080, 12'h83E);
        chk(timeout === 1'b1, "slow page load not cut off");
        model.slow = 1'b0;
        run_cmd(NFC_OP_RESET, 16'h0000, 12'h000);
        chk(timeout === 1'b0, "reset busy too long");
        run_cmd(NFC_OP_STATUS, 16'h0000, 12'h000);
        chk(status === 8'hC0 && fail === 1'b0, "status read");
        $display("test timeout done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        t_reset();
        t_scan();
        t_refuse();
        t_prog_read();
        t_fail();
        t_timeout();
        complete_run();
    end
endmodule
